// >>> src/aef_error_flags.sv
// Chosen here: the strobed register port.
`timescale 1ns/10ps
// Notes on behaviour
// - halting flags stop all conversion activity
// - soft reset clears the four halting flags
// - restart and load-ok flags clear by one
// - converter disabled holds all flags zero
// - writing zero keeps, writing one never sets
// - flag byte at 0x08, layout, reset zero
// - illegal store or outside fetch sets bit 7
// - reserved command or format sets bit 6
// - list without end-of-list sets bit 5
// - restart mode start errors set bit 3
// - trigger mode start before first restart
// - start before sequence completes is error
// - start during start processing is error
// - auto start colliding with request errors
// - restart before list end sets bit 2
// - restart overrun does not set bit 2
// - restart mode restart without load-ok sets bit 1
// - abort in progress or coincident suppresses bit 1
// - first restart or single buffer suppresses bit 1
// - flags request interrupt only when enabled
// - trigger mode restart sets start request
module aef_error_flags (
  input wire logic clock_in,             // module clock, 20 MHz
  input wire logic reset_n_in,           // async active-low reset
  input wire logic clk_en_in,            // freezes all state except the reset synchroniser when low
  input wire logic [aef_pkg::AEF_AW-1:0] addr_in, // register byte address
  input wire logic [7:0] wdata_in,       // register write data
  input wire logic wr_in,                // write strobe
  input wire logic rd_in,                // read strobe
  input wire aef_pkg::aef_events_t ev_in, // controller events
  output logic [7:0] rdata_out,          // read data, cycle after read
  output logic halt_out,                 // converter must cease operation
  output logic err_irq_out,              // converter error interrupt request
  output logic auto_start_out,           // automatic start request pulse
  output logic converter_enable_out,     // converter enable bit
  output logic trigger_mode_out          // 1 trigger mode, 0 restart mode
);
  import aef_pkg::*;

  // reset synchroniser
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire logic rst_n = rst_sync_reg; // released reset for the design

  // state registers
  logic [7:0] error_flag_reg;        // error flag byte
  logic [7:0] error_irq_enable_reg;  // error interrupt enable byte
  logic [7:0] ctrl_reg;              // enable, mode, buffer, abort select
  logic [7:0] rdata_reg;             // registered read data
  logic first_restart_reg;           // next restart is first after enable
  logic auto_start_reg;              // pending automatic start
  aef_state_t state_reg;
  aef_state_t state_next;

  // address decode
  function automatic logic hit(input logic [AEF_AW-1:0] a,
                               input logic [AEF_AW-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire logic wr_flag = wr_in && hit(addr_in, AEF_ERR_FLAG_OFS);
  wire logic wr_ie = wr_in && hit(addr_in, AEF_ERR_IE_OFS);
  wire logic wr_ctrl = wr_in && hit(addr_in, AEF_CTRL_OFS);
  // soft reset is a self-clearing command bit
  wire logic soft_reset = wr_ctrl && wdata_in[AEF_CTRL_SR_BIT];
  wire logic conv_en = ctrl_reg[AEF_CTRL_EN_BIT];
  wire logic sequence_start_request_mode = ctrl_reg[AEF_CTRL_TRIGMODE_BIT];
  wire logic dbuf_mode = ctrl_reg[AEF_CTRL_DBUF_BIT];
  wire logic abort_at_list_end_select = ctrl_reg[AEF_CTRL_STRSEQA_BIT];

  // halted by any severe flag
  wire logic halted = |(error_flag_reg & AEF_FLAG_HALT_MASK);
  wire logic live = conv_en && !halted;

  // automatic start after a restart in trigger mode
  wire logic auto_start = auto_start_reg;

  // sequence start error detection
  wire logic start_any = ev_in.start_ev || auto_start;
  wire logic sequence_start_request_collide = sequence_start_request_mode && auto_start && ev_in.start_ev;
  wire logic sequence_start_request_rm_err = !sequence_start_request_mode && start_any &&
    (state_reg == AEF_ABORTED || state_reg == AEF_LOADING);
  wire logic sequence_start_request_tm_err = sequence_start_request_mode && ev_in.start_ev &&
    (state_reg == AEF_IDLE_INIT);
  wire logic sequence_start_request_busy_err = start_any &&
    (state_reg == AEF_RUNNING || state_reg == AEF_STARTING);
  wire logic set_sequence_start_request = live &&
    (sequence_start_request_collide || sequence_start_request_rm_err || sequence_start_request_tm_err || sequence_start_request_busy_err);

  // other severe errors
  wire logic set_ia = live &&
    (ev_in.store_illegal || ev_in.fetch_outside);
  wire logic set_cmd = live &&
    (ev_in.cmd_reserved || ev_in.fmt_reserved);
  wire logic set_eol = live && ev_in.list_no_end;

  // restart request error: restart while sequence still open
  wire logic list_closing = ev_in.eol_executed ||
    (abort_at_list_end_select && ev_in.eol_about) || ev_in.abort_req || ev_in.abort_busy;
  wire logic set_rstar = live && ev_in.restart_ev && !ev_in.restart_overrun &&
    (state_reg == AEF_RUNNING || state_reg == AEF_STARTING) &&
    !list_closing;

  // load-ok error, restart mode only
  wire logic set_load_ok = live && !sequence_start_request_mode && ev_in.restart_ev &&
    !ev_in.load_ok && !ev_in.abort_busy && !ev_in.abort_req &&
    !first_restart_reg && dbuf_mode;

  wire logic [7:0] set_vec = {set_ia, set_cmd, set_eol, 1'b0, set_sequence_start_request,
                              set_rstar, set_load_ok, 1'b0};
  // write one clears writable bits only; zeros keep, ones never set
  wire logic [7:0] clr_vec = wr_flag ? (wdata_in & AEF_FLAG_W1C_MASK)
                                     : 8'h00;
  wire logic [7:0] flag_next = conv_en
    ? (soft_reset ? AEF_FLAG_RESET
                  : ((error_flag_reg & ~clr_vec) | set_vec))
    : AEF_FLAG_RESET;

  // sequence tracker next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      AEF_IDLE_INIT: begin
        if (ev_in.restart_ev) state_next = AEF_LOADING;
      end
      AEF_LOADING: begin
        if (ev_in.restart_loaded) state_next = AEF_READY;
      end
      AEF_READY: begin
        if (start_any) state_next = AEF_STARTING;
        else if (ev_in.seq_aborted) state_next = AEF_ABORTED;
      end
      AEF_STARTING: begin
        if (ev_in.first_sampling) state_next = AEF_RUNNING;
      end
      AEF_RUNNING: begin
        if (ev_in.seq_aborted) state_next = AEF_ABORTED;
        else if (ev_in.restart_ev) state_next = AEF_LOADING;
        else if (ev_in.seq_done) state_next = AEF_READY;
      end
      AEF_ABORTED: begin
        if (ev_in.restart_ev) state_next = AEF_LOADING;
      end
      default: begin
        state_next = AEF_IDLE_INIT;
      end
    endcase
  end

  // read mux
  wire logic [7:0] rd_mux =
    hit(addr_in, AEF_ERR_FLAG_OFS) ? (error_flag_reg & AEF_FLAG_IMPL_MASK) :
    hit(addr_in, AEF_ERR_IE_OFS) ? (error_irq_enable_reg & AEF_FLAG_IMPL_MASK) :
    hit(addr_in, AEF_CTRL_OFS) ? (ctrl_reg & AEF_CTRL_MASK) :
    hit(addr_in, AEF_STAT_OFS) ? {5'h00, 3'(state_reg)} : 8'h00;

  // flag, enable and control registers
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      error_flag_reg <= AEF_FLAG_RESET;
      error_irq_enable_reg <= AEF_IE_RESET;
      ctrl_reg <= AEF_CTRL_RESET;
      rdata_reg <= 8'h00;
    end else if (clk_en_in) begin
      error_flag_reg <= flag_next;
      if (wr_ie) error_irq_enable_reg <= wdata_in & AEF_FLAG_IMPL_MASK;
      if (wr_ctrl) ctrl_reg <= wdata_in & AEF_CTRL_MASK;
      rdata_reg <= rd_in ? rd_mux : 8'h00;
    end
  end

  // tracker, first-restart marker and automatic start
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= AEF_IDLE_INIT;
      first_restart_reg <= 1'b1;
      auto_start_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (!conv_en || soft_reset || halted) begin
        // disable, soft reset or halt: back to initial state
        state_reg <= AEF_IDLE_INIT;
        first_restart_reg <= 1'b1;
        auto_start_reg <= 1'b0;
      end else begin
        state_reg <= state_next;
        if (ev_in.restart_ev || ev_in.stop_exit)
          first_restart_reg <= ev_in.stop_exit;
        auto_start_reg <= sequence_start_request_mode && ev_in.restart_ev;
      end
    end
  end

  // outputs
  assign rdata_out = rdata_reg;
  assign halt_out = halted || !conv_en;
  assign err_irq_out = |(error_flag_reg & error_irq_enable_reg);
  assign auto_start_out = auto_start_reg && live;
  assign converter_enable_out = conv_en;
  assign trigger_mode_out = sequence_start_request_mode;

  // checks: halt and enable
  halt_stops_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    halted
    |-> halt_out)
    else $error("halt not driven by severe flag");
  disabled_halt_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    !conv_en
    |-> halt_out)
    else $error("disabled converter not halted");
  nonhalt_flags_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    conv_en && (error_flag_reg & AEF_FLAG_HALT_MASK) == 8'h00
    |-> !halt_out)
    else $error("mild flag halted converter");
  disabled_zero_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && !conv_en
    |=> error_flag_reg == 8'h00)
    else $error("flags not cleared while disabled");
  soft_reset_clr_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && soft_reset
    |=> error_flag_reg == 8'h00)
    else $error("soft reset did not clear flags");
  // checks: register layout and read port
  reserved_bits_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    1'b1
    |-> error_flag_reg[4] == 1'b0 && error_flag_reg[0] == 1'b0)
    else $error("reserved flag bit set");
  rdata_idle_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && !rd_in
    |=> rdata_out == 8'h00)
    else $error("read data without read");
  flag_read_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && rd_in && addr_in == AEF_ERR_FLAG_OFS
    |=> rdata_out == $past(error_flag_reg))
    else $error("flag byte read wrong");
  frozen_flags_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    !clk_en_in
    |=> $stable(error_flag_reg))
    else $error("flags moved with clock enable low");
  // checks: software writes
  w1c_clear_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && wr_flag && wdata_in[AEF_RSTAR_BIT] && !set_rstar
    |=> !error_flag_reg[AEF_RSTAR_BIT])
    else $error("restart error flag not cleared");
  load_ok_clear_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && wr_flag && wdata_in[AEF_LOAD_OK_BIT] && !set_load_ok
    |=> !error_flag_reg[AEF_LOAD_OK_BIT])
    else $error("load-ok error flag not cleared");
  write_no_set_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && wr_flag && set_vec == 8'h00
    |=> (error_flag_reg & ~$past(error_flag_reg)) == 8'h00)
    else $error("write set a flag");
  write_zero_keep_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && conv_en && !soft_reset && wr_flag &&
    !wdata_in[AEF_RSTAR_BIT] && error_flag_reg[AEF_RSTAR_BIT]
    |=> error_flag_reg[AEF_RSTAR_BIT])
    else $error("write of zero cleared a flag");
  // checks: severe flags stay until soft reset or disable
  severe_sticky_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && conv_en && !soft_reset && error_flag_reg[AEF_IA_BIT]
    |=> error_flag_reg[AEF_IA_BIT])
    else $error("illegal access flag lost");
  cmd_sticky_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && conv_en && !soft_reset && error_flag_reg[AEF_CMD_BIT]
    |=> error_flag_reg[AEF_CMD_BIT])
    else $error("bad command flag lost");
  eol_sticky_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && conv_en && !soft_reset && error_flag_reg[AEF_EOL_BIT]
    |=> error_flag_reg[AEF_EOL_BIT])
    else $error("missing list end flag lost");
  sequence_start_request_sticky_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && conv_en && !soft_reset && error_flag_reg[AEF_SEQUENCE_START_REQUEST_BIT]
    |=> error_flag_reg[AEF_SEQUENCE_START_REQUEST_BIT])
    else $error("sequence start flag lost");
  // checks: severe flag setting
  ia_set_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && live && !soft_reset && ev_in.store_illegal
    |=> error_flag_reg[AEF_IA_BIT])
    else $error("illegal access not flagged");
  fetch_set_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && live && !soft_reset && ev_in.fetch_outside
    |=> error_flag_reg[AEF_IA_BIT])
    else $error("outside fetch not flagged");
  cmd_set_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && live && !soft_reset && ev_in.cmd_reserved
    |=> error_flag_reg[AEF_CMD_BIT])
    else $error("bad command not flagged");
  fmt_set_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && live && !soft_reset && ev_in.fmt_reserved
    |=> error_flag_reg[AEF_CMD_BIT])
    else $error("bad format not flagged");
  eol_set_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && live && !soft_reset && ev_in.list_no_end
    |=> error_flag_reg[AEF_EOL_BIT])
    else $error("missing list end not flagged");
  // checks: sequence start errors
  rm_abort_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && live && !soft_reset && !sequence_start_request_mode && start_any &&
    state_reg == AEF_ABORTED
    |=> error_flag_reg[AEF_SEQUENCE_START_REQUEST_BIT])
    else $error("start after abort not flagged");
  tm_early_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && live && !soft_reset && sequence_start_request_mode && ev_in.start_ev &&
    state_reg == AEF_IDLE_INIT
    |=> error_flag_reg[AEF_SEQUENCE_START_REQUEST_BIT])
    else $error("start before first restart not flagged");
  run_start_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && live && !soft_reset && start_any &&
    state_reg == AEF_RUNNING
    |=> error_flag_reg[AEF_SEQUENCE_START_REQUEST_BIT])
    else $error("start while running not flagged");
  busy_start_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && live && !soft_reset && start_any &&
    state_reg == AEF_STARTING
    |=> error_flag_reg[AEF_SEQUENCE_START_REQUEST_BIT])
    else $error("start while starting not flagged");
  collide_sequence_start_request_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && live && !soft_reset && sequence_start_request_mode && auto_start &&
    ev_in.start_ev
    |=> error_flag_reg[AEF_SEQUENCE_START_REQUEST_BIT])
    else $error("start collision not flagged");
  // checks: restart request and load-ok errors
  rstar_set_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && !soft_reset && set_rstar
    |=> error_flag_reg[AEF_RSTAR_BIT])
    else $error("restart error not flagged");
  overrun_quiet_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    ev_in.restart_overrun
    |-> !set_rstar)
    else $error("restart error on overrun");
  load_ok_set_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && !soft_reset && set_load_ok
    |=> error_flag_reg[AEF_LOAD_OK_BIT])
    else $error("load-ok error not flagged");
  load_ok_trigmode_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    sequence_start_request_mode
    |-> !set_load_ok)
    else $error("load-ok error in trigger mode");
  load_ok_abort_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    ev_in.abort_busy || ev_in.abort_req
    |-> !set_load_ok)
    else $error("load-ok error during abort");
  load_ok_single_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    !dbuf_mode || first_restart_reg
    |-> !set_load_ok)
    else $error("load-ok error on first restart");
  // checks: interrupt and automatic start
  irq_gate_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    error_irq_enable_reg == 8'h00
    |-> !err_irq_out)
    else $error("interrupt without enable");
  irq_raise_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    error_flag_reg[AEF_IA_BIT] && error_irq_enable_reg[AEF_IA_BIT]
    |-> err_irq_out)
    else $error("enabled flag gave no interrupt");
  auto_start_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && live && !soft_reset && sequence_start_request_mode && ev_in.restart_ev
    |=> auto_start_reg)
    else $error("no automatic start after restart");
  no_auto_rm_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    clk_en_in && !sequence_start_request_mode
    |=> !auto_start_reg)
    else $error("automatic start in restart mode");
endmodule : aef_error_flags

// >>> src/aef_pkg.sv
package aef_pkg;
  // register map (byte offsets on the plain register port)
  localparam logic [4:0] AEF_ERR_IE_OFS = 5'h06; // error interrupt enable byte
  localparam logic [4:0] AEF_ERR_FLAG_OFS = 5'h08; // error flag byte
  localparam logic [4:0] AEF_CTRL_OFS = 5'h00; // control byte
  localparam logic [4:0] AEF_STAT_OFS = 5'h01; // status byte
  localparam int AEF_AW = 5;
  // error flag bit positions
  localparam int AEF_IA_BIT = 7;
  localparam int AEF_CMD_BIT = 6;
  localparam int AEF_EOL_BIT = 5;
  localparam int AEF_SEQUENCE_START_REQUEST_BIT = 3;
  localparam int AEF_RSTAR_BIT = 2;
  localparam int AEF_LOAD_OK_BIT = 1;
  // writable and implemented masks
  localparam logic [7:0] AEF_FLAG_W1C_MASK = 8'h06;
  localparam logic [7:0] AEF_FLAG_IMPL_MASK = 8'hEE;
  localparam logic [7:0] AEF_FLAG_HALT_MASK = 8'hE8;
  localparam logic [7:0] AEF_FLAG_RESET = 8'h00;
  localparam logic [7:0] AEF_IE_RESET = 8'h00;
  // control byte fields
  localparam int AEF_CTRL_EN_BIT = 7;
  localparam int AEF_CTRL_SR_BIT = 6;
  localparam int AEF_CTRL_TRIGMODE_BIT = 2;
  localparam int AEF_CTRL_DBUF_BIT = 1;
  localparam int AEF_CTRL_STRSEQA_BIT = 0;
  localparam logic [7:0] AEF_CTRL_RESET = 8'h00;
  localparam logic [7:0] AEF_CTRL_MASK = 8'h87;

  // hardware events from the conversion controller, one-cycle pulses except the abort_busy and load_ok levels
  typedef struct packed {
    logic store_illegal;    // result store hit an illegal access
    logic fetch_outside;    // command fetched outside ram or nvm
    logic cmd_reserved;     // loaded command has reserved bits
    logic fmt_reserved;     // reserved result format select
    logic list_no_end;      // list lacks an end-of-list command
    logic start_ev;         // start event from bus or internal interface
    logic restart_ev;       // restart request
    logic restart_loaded;   // restart finished loading first command
    logic seq_aborted;      // sequence aborted
    logic seq_done;         // sequence completed
    logic first_sampling;   // first command of sequence begins sampling
    logic eol_executed;     // end-of-list executed
    logic eol_about;        // end-of-list about to execute
    logic abort_req;        // sequence abort request
    logic abort_busy;       // sequence abort in progress (level)
    logic restart_overrun;  // restart request overrun scenario
    logic load_ok;          // load-ok bit state (level)
    logic stop_exit;        // stop mode exit
  } aef_events_t;

  // states of the sequence tracker
  typedef enum logic [2:0] {
    AEF_IDLE_INIT,   // enabled, no restart seen yet
    AEF_LOADING,     // restart loading first command
    AEF_READY,       // loaded, waiting for start
    AEF_STARTING,    // start accepted, first command pending sample
    AEF_RUNNING,     // sequence running
    AEF_ABORTED      // aborted, needs restart
  } aef_state_t;
endpackage : aef_pkg

// >>> testbench/aef_testbench.sv
`timescale 1ns/10ps
module testbench;
  import aef_pkg::*;
  // one table row: control byte, event steps, expected results
  typedef struct {
    logic [7:0] ctrl; // control byte written first
    logic [17:0] ev [4]; // event steps, zero steps skipped
    logic [7:0] flags; // flag byte expected afterwards
    logic halt; // halt level expected afterwards
  } aef_tb_row_t;
  logic clock_in = 1'b0; // 20 MHz module clock
  logic reset_n_in = 1'b0; // active-low reset
  logic clk_en_in = 1'b1; // clock enable
  logic [AEF_AW-1:0] addr_in = '0; // register address
  logic [7:0] wdata_in = 8'h00; // write data
  logic wr_in = 1'b0; // write strobe
  logic rd_in = 1'b0; // read strobe
  aef_events_t ev_in = '0; // controller events
  logic [7:0] rdata_out; // read data
  logic halt_out; // halt level
  logic err_irq_out; // error interrupt request
  logic auto_start_out; // automatic start pulse
  logic converter_enable_out; // enable bit
  logic trigger_mode_out; // mode bit
  int n_mismatch = 0; // mismatches seen
  int cmp_count = 0; // comparisons made
  int cycles = 0; // cycles since start
  // event steps: 20000 illegal store, 10000 outside fetch, 08000 bad cmd,
  // 04000 bad format, 02000 no list end, 01000 start, 00800 restart,
  // 00400 restart loaded, 00010 abort request, 00002 load-ok level
  aef_tb_row_t rows [15] = '{
    '{8'h80, '{18'h20000, 0, 0, 0}, 8'h80, 1'b1},
    '{8'h80, '{18'h10000, 0, 0, 0}, 8'h80, 1'b1},
    '{8'h80, '{18'h08000, 0, 0, 0}, 8'h40, 1'b1},
    '{8'h80, '{18'h04000, 0, 0, 0}, 8'h40, 1'b1},
    '{8'h80, '{18'h02000, 0, 0, 0}, 8'h20, 1'b1},
    '{8'h84, '{18'h01000, 0, 0, 0}, 8'h08, 1'b1},
    '{8'h82, '{18'h00802, 18'h00400, 18'h01000, 18'h00802},
      8'h04, 1'b0},
    '{8'h82, '{18'h00802, 18'h00400, 18'h00800, 0}, 8'h02, 1'b0},
    '{8'h80, '{18'h00802, 18'h00400, 18'h00800, 0}, 8'h00, 1'b0},
    '{8'h82, '{18'h00800, 0, 0, 0}, 8'h00, 1'b0},
    '{8'h82, '{18'h00802, 18'h00400, 18'h00810, 0}, 8'h00, 1'b0},
    '{8'h82, '{18'h00802, 18'h00400, 18'h01000, 18'h01000},
      8'h08, 1'b1},
    '{8'h84, '{18'h00800, 18'h01000, 0, 0}, 8'h08, 1'b1},
    '{8'h82, '{18'h00800, 18'h01000, 0, 0}, 8'h08, 1'b1},
    '{8'h82, '{18'h00802, 18'h00400, 18'h01000, 18'h00806},
      8'h00, 1'b0}
  };

  aef_error_flags aef_error_flags_inst (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .ev_in(ev_in), .rdata_out(rdata_out), .halt_out(halt_out),
    .err_irq_out(err_irq_out), .auto_start_out(auto_start_out),
    .converter_enable_out(converter_enable_out),
    .trigger_mode_out(trigger_mode_out)
  );

  // free-running clock, 50 ns period
  always #25 clock_in = ~clock_in;

  // hang guard
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // compare and count
  task automatic chk(input logic [7:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one-cycle register write
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask : wr

  // one-cycle read, data taken in the following cycle
  task automatic rdchk(input logic [4:0] a, input logic [7:0] e, string w);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    chk(rdata_out, e, w);
  endtask : rdchk

  // set mode, play event steps back to back, check flags and halt
  task automatic apply(input aef_tb_row_t r);
    wr(AEF_CTRL_OFS, r.ctrl);
    for (int i = 0; i < 4; i++) begin
      if (r.ev[i] !== 18'h0) begin
        @(posedge clock_in);
        ev_in <= r.ev[i];
      end
    end
    @(posedge clock_in);
    ev_in <= '0;
    rdchk(AEF_ERR_FLAG_OFS, r.flags, "flags");
    chk(halt_out, r.halt, "halt");
  endtask : apply

  // verdict and end of run
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // main sequence
  initial begin
    repeat (20) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rdchk(AEF_ERR_FLAG_OFS, 8'h00, "flag reset");
    rdchk(AEF_ERR_IE_OFS, 8'h00, "enable reset");
    chk(halt_out, 1'b1, "halt disabled");
    foreach (rows[i]) begin
      apply(rows[i]);
      wr(AEF_ERR_IE_OFS, ~rows[i].flags & 8'hEE);
      @(negedge clock_in);
      chk(err_irq_out, 1'b0, "irq masked");
      wr(AEF_ERR_IE_OFS, rows[i].flags);
      @(negedge clock_in);
      chk(err_irq_out, |rows[i].flags, "irq enabled");
      wr(AEF_CTRL_OFS, rows[i].ctrl | 8'h40);
      rdchk(AEF_ERR_FLAG_OFS, 8'h00, "soft reset");
      chk(halt_out, 1'b0, "halt after soft reset");
      wr(AEF_CTRL_OFS, 8'h00);
    end
    rdchk(5'h1F, 8'h00, "unmapped");
    apply(rows[7]);
    wr(AEF_ERR_FLAG_OFS, 8'h00);
    rdchk(AEF_ERR_FLAG_OFS, 8'h02, "write zero");
    wr(AEF_ERR_FLAG_OFS, 8'hFD);
    rdchk(AEF_ERR_FLAG_OFS, 8'h02, "write one no set");
    wr(AEF_ERR_FLAG_OFS, 8'h02);
    rdchk(AEF_ERR_FLAG_OFS, 8'h00, "write one clear");
    apply(rows[7]);
    wr(AEF_CTRL_OFS, 8'h00);
    rdchk(AEF_ERR_FLAG_OFS, 8'h00, "disabled");
    chk(converter_enable_out, 1'b0, "enable off");
    chk(halt_out, 1'b1, "halt disabled");
    wr(AEF_CTRL_OFS, 8'h84);
    @(negedge clock_in);
    chk(trigger_mode_out, 1'b1, "mode bit");
    chk(converter_enable_out, 1'b1, "enable bit");
    @(posedge clock_in);
    ev_in <= 18'h00800;
    @(posedge clock_in);
    ev_in <= '0;
    @(negedge clock_in);
    chk(auto_start_out, 1'b1, "auto start");
    wr(AEF_CTRL_OFS, 8'hC0);
    @(posedge clock_in);
    clk_en_in <= 1'b0;
    ev_in <= 18'h20000;
    @(posedge clock_in);
    clk_en_in <= 1'b1;
    ev_in <= '0;
    rdchk(AEF_ERR_FLAG_OFS, 8'h00, "frozen");
    stop_test();
  end
endmodule : testbench
